// ---- verilog/bmw_regs.v ----
// Memory window register bank with AXI4-Lite slave and window lookup
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "bmw_defs.vh"

module bmw_regs #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              CLK,
  input  wire              NRST,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] AWADDR,
  input  wire [2:0]        AWPROT,
  input  wire              AWVALID,
  output reg               AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output reg               WREADY,
  // AXI4-Lite write response
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] ARADDR,
  input  wire [2:0]        ARPROT,
  input  wire              ARVALID,
  output reg               ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY,
  // Forwarding lookup
  input  wire [63:0]       LOOKUP_ADDR,
  input  wire              LOOKUP_VALID,
  output reg               HIT_VALID,
  output reg               NP_HIT,
  output reg               PF_HIT,
  // Window mode
  output reg               PF_ADDR64
);

  // Register state
  reg [11:0]       np_base_reg;
  reg [11:0]       np_base_next;
  reg [11:0]       np_limit_reg;
  reg [11:0]       np_limit_next;
  reg [11:0]       pf_base_reg;
  reg [11:0]       pf_base_next;
  reg [11:0]       pf_limit_reg;
  reg [11:0]       pf_limit_next;
  reg              cap_reg;
  reg              cap_next;
  reg [31:0]       pf_base_hi_reg;
  reg [31:0]       pf_base_hi_next;
  reg [31:0]       pf_lim_hi_reg;
  reg [31:0]       pf_lim_hi_next;
  reg              unlock_reg;
  reg              unlock_next;

  // Bus state
  reg              aw_held_reg;
  reg              aw_held_next;
  reg [5:0]        aw_idx_reg;
  reg [5:0]        aw_idx_next;
  reg              w_held_reg;
  reg              w_held_next;
  reg [31:0]       w_data_reg;
  reg [31:0]       w_data_next;
  reg [3:0]        w_strb_reg;
  reg [3:0]        w_strb_next;
  reg              awready_next;
  reg              wready_next;
  reg              bvalid_next;
  reg [1:0]        bresp_next;
  reg              arready_next;
  reg              rvalid_next;
  reg [31:0]       rdata_next;
  reg [1:0]        rresp_next;

  // Lookup state
  reg              hit_valid_next;
  reg              np_hit_next;
  reg              pf_hit_next;

  // Combinational helpers
  reg [31:0]       wmerged;
  reg [5:0]        ar_idx;
  reg [31:0]       np_lo;
  reg [31:0]       np_hi;
  reg [63:0]       pf_lo;
  reg [63:0]       pf_hi;

  // Byte-lane merge of a write into the current value
  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer i;
    begin
      merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Mapped register indices
  function mapped;
    input [5:0] idx;
    begin
      case (idx)
        `BMW_IDX_NP_BASE,
        `BMW_IDX_NP_LIMIT,
        `BMW_IDX_PF_BASE,
        `BMW_IDX_PF_LIMIT,
        `BMW_IDX_PF_BASE_HI,
        `BMW_IDX_PF_LIM_HI,
        `BMW_IDX_UNLOCK: mapped = 1'b1;
        default:         mapped = 1'b0;
      endcase
    end
  endfunction

  // Current word of a register as software reads it
  function [31:0] current;
    input [5:0] idx;
    begin
      case (idx)
        `BMW_IDX_NP_BASE:
          current = {16'h0000, np_base_reg, 4'h0};
        `BMW_IDX_NP_LIMIT:
          current = {16'h0000, np_limit_reg, 4'h0};
        `BMW_IDX_PF_BASE:
          current = {16'h0000, pf_base_reg, `BMW_RSV_ZERO, cap_reg};
        `BMW_IDX_PF_LIMIT:
          current = {16'h0000, pf_limit_reg, `BMW_RSV_ZERO, cap_reg};
        `BMW_IDX_PF_BASE_HI:
          current = cap_reg ? pf_base_hi_reg : 32'h00000000;
        `BMW_IDX_PF_LIM_HI:
          current = cap_reg ? pf_lim_hi_reg : 32'h00000000;
        `BMW_IDX_UNLOCK:
          current = {31'h0, unlock_reg};
        default:
          current = 32'h00000000;
      endcase
    end
  endfunction

  // Bus handshakes and register writes
  always @* begin
    aw_held_next    = aw_held_reg;
    aw_idx_next     = aw_idx_reg;
    w_held_next     = w_held_reg;
    w_data_next     = w_data_reg;
    w_strb_next     = w_strb_reg;
    bvalid_next     = BVALID;
    bresp_next      = BRESP;
    arready_next    = ARREADY;
    rvalid_next     = RVALID;
    rdata_next      = RDATA;
    rresp_next      = RRESP;
    np_base_next    = np_base_reg;
    np_limit_next   = np_limit_reg;
    pf_base_next    = pf_base_reg;
    pf_limit_next   = pf_limit_reg;
    cap_next        = cap_reg;
    pf_base_hi_next = pf_base_hi_reg;
    pf_lim_hi_next  = pf_lim_hi_reg;
    unlock_next     = unlock_reg;
    ar_idx          = ARADDR[7:2];
    wmerged         = merge(current(aw_idx_reg), w_data_reg, w_strb_reg);

    if (AWVALID && AWREADY) begin
      aw_held_next = 1'b1;
      aw_idx_next  = AWADDR[7:2];
    end
    if (WVALID && WREADY) begin
      w_held_next = 1'b1;
      w_data_next = WDATA;
      w_strb_next = WSTRB;
    end
    if (BVALID && BREADY) begin
      bvalid_next = 1'b0;
    end

    // Address and data both held: commit the write
    if (aw_held_reg && w_held_reg) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = mapped(aw_idx_reg) ? `BMW_RESP_OKAY : `BMW_RESP_SLVERR;
      case (aw_idx_reg)
        `BMW_IDX_NP_BASE:
          np_base_next = wmerged[`BMW_FLD_HI:`BMW_FLD_LO];
        `BMW_IDX_NP_LIMIT:
          np_limit_next = wmerged[`BMW_FLD_HI:`BMW_FLD_LO];
        `BMW_IDX_PF_BASE: begin
          pf_base_next = wmerged[`BMW_FLD_HI:`BMW_FLD_LO];
          if (unlock_reg) begin
            cap_next = wmerged[`BMW_CAP_BIT];
          end
        end
        `BMW_IDX_PF_LIMIT:
          pf_limit_next = wmerged[`BMW_FLD_HI:`BMW_FLD_LO];
        `BMW_IDX_PF_BASE_HI: begin
          if (cap_reg) begin
            pf_base_hi_next = wmerged;
          end
        end
        `BMW_IDX_PF_LIM_HI: begin
          if (cap_reg) begin
            pf_lim_hi_next = wmerged;
          end
        end
        `BMW_IDX_UNLOCK:
          unlock_next = wmerged[`BMW_UNLOCK_BIT];
        default: begin
        end
      endcase
    end

    // One read at a time; data is captured when the address is taken
    if (RVALID && RREADY) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
    if (ARVALID && ARREADY) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rdata_next   = current(ar_idx);
      rresp_next   = mapped(ar_idx) ? `BMW_RESP_OKAY : `BMW_RESP_SLVERR;
    end

    // Readies drop while a channel is held or a response waits
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next  = ~w_held_next & ~bvalid_next;
  end

  // Window lookup; uppers count as zero in 32-bit mode
  always @* begin
    np_lo = {np_base_reg, `BMW_BASE_FILL};
    np_hi = {np_limit_reg, `BMW_LIMIT_FILL};
    pf_lo = {(cap_reg ? pf_base_hi_reg : 32'h00000000),
             pf_base_reg, `BMW_BASE_FILL};
    pf_hi = {(cap_reg ? pf_lim_hi_reg : 32'h00000000),
             pf_limit_reg, `BMW_LIMIT_FILL};
    hit_valid_next = LOOKUP_VALID;
    // Non-prefetchable space lies below 4GB only
    np_hit_next = LOOKUP_VALID && (LOOKUP_ADDR[63:32] == 32'h00000000)
                  && (LOOKUP_ADDR[31:0] >= np_lo)
                  && (LOOKUP_ADDR[31:0] <= np_hi);
    pf_hit_next = LOOKUP_VALID && (LOOKUP_ADDR >= pf_lo)
                  && (LOOKUP_ADDR <= pf_hi);
  end

  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      np_base_reg    <= `BMW_RST_BASE;
      np_limit_reg   <= `BMW_RST_LIMIT;
      pf_base_reg    <= `BMW_RST_BASE;
      pf_limit_reg   <= `BMW_RST_LIMIT;
      cap_reg        <= `BMW_RST_CAP;
      pf_base_hi_reg <= `BMW_RST_BASE_HI;
      pf_lim_hi_reg  <= `BMW_RST_LIM_HI;
      unlock_reg     <= `BMW_RST_UNLOCK;
      aw_held_reg    <= 1'b0;
      aw_idx_reg     <= 6'h00;
      w_held_reg     <= 1'b0;
      w_data_reg     <= 32'h00000000;
      w_strb_reg     <= 4'h0;
      AWREADY        <= 1'b1;
      WREADY         <= 1'b1;
      BVALID         <= 1'b0;
      BRESP          <= `BMW_RESP_OKAY;
      ARREADY        <= 1'b1;
      RVALID         <= 1'b0;
      RDATA          <= 32'h00000000;
      RRESP          <= `BMW_RESP_OKAY;
      HIT_VALID      <= 1'b0;
      NP_HIT         <= 1'b0;
      PF_HIT         <= 1'b0;
      PF_ADDR64      <= `BMW_RST_CAP;
    end else begin
      np_base_reg    <= np_base_next;
      np_limit_reg   <= np_limit_next;
      pf_base_reg    <= pf_base_next;
      pf_limit_reg   <= pf_limit_next;
      cap_reg        <= cap_next;
      pf_base_hi_reg <= pf_base_hi_next;
      pf_lim_hi_reg  <= pf_lim_hi_next;
      unlock_reg     <= unlock_next;
      aw_held_reg    <= aw_held_next;
      aw_idx_reg     <= aw_idx_next;
      w_held_reg     <= w_held_next;
      w_data_reg     <= w_data_next;
      w_strb_reg     <= w_strb_next;
      AWREADY        <= awready_next;
      WREADY         <= wready_next;
      BVALID         <= bvalid_next;
      BRESP          <= bresp_next;
      ARREADY        <= arready_next;
      RVALID         <= rvalid_next;
      RDATA          <= rdata_next;
      RRESP          <= rresp_next;
      HIT_VALID      <= hit_valid_next;
      NP_HIT         <= np_hit_next;
      PF_HIT         <= pf_hit_next;
      PF_ADDR64      <= cap_next;
    end
  end

endmodule // bmw_regs

`default_nettype wire

// ---- verilog/bmw_defs.vh ----
// Constants for the bridge memory window register bank
// What this block does
// - Non-prefetch limit bits 15:4 hold A[31:20]
// - Non-prefetch base/limit pair decides forwarding
// - Capability flag bit 0, resets 1, lockable
// - Prefetch limit bit 0 mirrors capability flag
// - Prefetch base bits 15:4, reset 0xFFF
// - Prefetch base, limit, uppers decide forwarding
// - Base upper gives A[63:32], resets ones
// - Limit upper gives A[63:32], resets zero
// - Flag clear: uppers ignore writes, read zero
// - Non-prefetch base bits 15:4, reset 0xFFF
`ifndef BMW_DEFS_VH
`define BMW_DEFS_VH

// Register indices; byte address is four times the index
`define BMW_IDX_NP_BASE    6'h20
`define BMW_IDX_NP_LIMIT   6'h22
`define BMW_IDX_PF_BASE    6'h24
`define BMW_IDX_PF_LIMIT   6'h26
`define BMW_IDX_PF_BASE_HI 6'h28
`define BMW_IDX_PF_LIM_HI  6'h2C
`define BMW_IDX_UNLOCK     6'h30

// Field layout
`define BMW_FLD_HI   15
`define BMW_FLD_LO   4
`define BMW_CAP_BIT  0
`define BMW_UNLOCK_BIT 0
`define BMW_RSV_ZERO 3'h0

// Reset values
`define BMW_RST_BASE    12'hFFF
`define BMW_RST_LIMIT   12'h000
`define BMW_RST_CAP     1'b1
`define BMW_RST_BASE_HI 32'hFFFFFFFF
`define BMW_RST_LIM_HI  32'h00000000
`define BMW_RST_UNLOCK  1'b0

// Implied low address bits of a window
`define BMW_BASE_FILL  20'h00000
`define BMW_LIMIT_FILL 20'hFFFFF

// Bus answers
`define BMW_RESP_OKAY   2'h0
`define BMW_RESP_SLVERR 2'h2

`endif

// ---- sim/bmw_regs_sva.sv ----
// Checker for bus handshakes, read-back fields and window lookup
`timescale 1ns/100ps
`default_nettype none
`include "bmw_defs.vh"
module bmw_regs_sva #(parameter ADDR_W = 8) (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              NRST,
  // Write side
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic              BREADY,
  // Read side
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  input wire logic              RREADY,
  // Lookup
  input wire logic [63:0]       LOOKUP_ADDR,
  input wire logic              LOOKUP_VALID,
  input wire logic              HIT_VALID,
  input wire logic              NP_HIT,
  input wire logic              PF_ADDR64
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  reg [5:0] ridx_reg;
  // Index of the read in flight, so its data can be judged by register
  always @(posedge CLK or negedge NRST)
    if (!NRST) ridx_reg <= 6'h00;
    else if (ARVALID && ARREADY) ridx_reg <= ARADDR[7:2];
  wire up_idx = ridx_reg == `BMW_IDX_PF_BASE_HI || ridx_reg == `BMW_IDX_PF_LIM_HI;
  wire cap_idx = ridx_reg == `BMW_IDX_PF_BASE || ridx_reg == `BMW_IDX_PF_LIMIT;

  lookup_delay_a: assert property (LOOKUP_VALID |=> HIT_VALID) else $error("hit valid late");
  np_below4g_a: assert property (LOOKUP_VALID && LOOKUP_ADDR[63:32] != 32'h0 |=> !NP_HIT)
    else $error("np hit above 4G");
  rsv_zero_a: assert property (RVALID && ridx_reg[5:3] == 3'h4 |-> RDATA[31:16] == 16'h0 && RDATA[3:1] == 3'h0)
    else $error("reserved bits set");
  cap_mirror_a: assert property (RVALID && cap_idx |-> RDATA[0] == PF_ADDR64) else $error("cap bit differs");
  upper_zero_a: assert property (RVALID && up_idx && !PF_ADDR64 |-> RDATA == 32'h0)
    else $error("upper not zero");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY) else $error("read answer late");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read data moved");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write resp moved");
  b_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write resp late");
  unmapped_a: assert property (RVALID && RRESP == `BMW_RESP_SLVERR |-> RDATA == 32'h0) else $error("error data");
endmodule // bmw_regs_sva
`default_nettype wire

// ---- sim/bmw_regs_tb.sv ----
// Self-checking bench for the memory window register bank
`timescale 1ns/100ps
`default_nettype none
`include "bmw_defs.vh"
module bmw_regs_tb;
  logic        CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY, LOOKUP_VALID;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA;
  logic [3:0]  WSTRB;
  logic [63:0] LOOKUP_ADDR;
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, HIT_VALID, NP_HIT, PF_HIT, PF_ADDR64;
  wire  [1:0]  BRESP, RRESP;
  wire  [31:0] RDATA;
  int          fail_count, n_compared;
  localparam logic [7:0] NPB = {`BMW_IDX_NP_BASE, 2'h0};
  localparam logic [7:0] NPL = {`BMW_IDX_NP_LIMIT, 2'h0};
  localparam logic [7:0] PFB = {`BMW_IDX_PF_BASE, 2'h0};
  localparam logic [7:0] PFL = {`BMW_IDX_PF_LIMIT, 2'h0};
  localparam logic [7:0] BHI = {`BMW_IDX_PF_BASE_HI, 2'h0};
  localparam logic [7:0] LHI = {`BMW_IDX_PF_LIM_HI, 2'h0};
  localparam logic [7:0] UNL = {`BMW_IDX_UNLOCK, 2'h0};

  bmw_regs #(.ADDR_W(8)) DUT (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .LOOKUP_ADDR(LOOKUP_ADDR),
    .LOOKUP_VALID(LOOKUP_VALID), .HIT_VALID(HIT_VALID), .NP_HIT(NP_HIT), .PF_HIT(PF_HIT), .PF_ADDR64(PF_ADDR64));

  always #5 CLK = ~CLK;

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Response is taken late on purpose so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1;
    WVALID <= 1;
    while (!(aw && w)) begin
      @(posedge CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1;
        WVALID <= 0;
      end
    end
    do @(posedge CLK); while (BVALID !== 1'b1);
    chk("bresp", er, BRESP);
    BREADY <= 1;
    @(posedge CLK);
    BREADY <= 0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ARADDR <= a;
    ARVALID <= 1;
    do @(posedge CLK); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    do @(posedge CLK); while (RVALID !== 1'b1);
    chk("rdata", e, RDATA);
    chk("rresp", er, RRESP);
    RREADY <= 1;
    @(posedge CLK);
    RREADY <= 0;
  endtask

  task automatic lk(input logic [63:0] a, input logic enp, input logic epf);
    LOOKUP_ADDR <= a;
    LOOKUP_VALID <= 1;
    @(posedge CLK);
    LOOKUP_VALID <= 0;
    #1;
    chk("hit_valid", 1, HIT_VALID);
    chk("np_hit", enp, NP_HIT);
    chk("pf_hit", epf, PF_HIT);
    @(posedge CLK);
  endtask

  task automatic t_reset;
    chk("pf_addr64", 1, PF_ADDR64);
    rc(NPB, 32'h0000FFF0, 0);
    rc(NPL, 32'h00000000, 0);
    rc(PFB, 32'h0000FFF1, 0);
    rc(PFL, 32'h00000001, 0);
    rc(BHI, 32'hFFFFFFFF, 0);
    rc(LHI, 32'h00000000, 0);
  endtask

  // Reserved bits, locked flag, byte strobes and an unmapped place
  task automatic t_fields;
    wr(NPL, 32'hFFFFFFFF, 4'hF, 0);
    rc(NPL, 32'h0000FFF0, 0);
    wr(PFB, 32'hFFFF0000, 4'hF, 0);
    rc(PFB, 32'h00000001, 0);
    wr(PFL, 32'h0000FFFF, 4'h1, 0);
    rc(PFL, 32'h000000F1, 0);
    wr(8'h84, 32'h12345678, 4'hF, `BMW_RESP_SLVERR);
    rc(8'h84, 32'h0, `BMW_RESP_SLVERR);
  endtask

  task automatic t_np;
    wr(NPB, 32'h00001230, 4'hF, 0);
    wr(NPL, 32'h00001240, 4'hF, 0);
    lk(64'h12300000, 1, 0);
    lk(64'h122FFFFF, 0, 0);
    lk(64'h124FFFFF, 1, 0);
    lk(64'h12500000, 0, 0);
    lk(64'h1_12300000, 0, 0);
  endtask

  task automatic t_pf64;
    wr(BHI, 32'h1, 4'hF, 0);
    wr(LHI, 32'h1, 4'hF, 0);
    wr(PFB, 32'h0100, 4'hF, 0);
    wr(PFL, 32'h0200, 4'hF, 0);
    lk(64'h1_01000000, 0, 1);
    lk(64'h1_020FFFFF, 0, 1);
    lk(64'h1_00FFFFFF, 0, 0);
    lk(64'h1_02100000, 0, 0);
    lk(64'h0_01000000, 0, 0);
  endtask

  // Clearing the flag hides the uppers; their stored values come back
  task automatic t_cap;
    wr(UNL, 32'h1, 4'hF, 0);
    rc(UNL, 32'h00000001, 0);
    wr(PFB, 32'h0100, 4'hF, 0);
    chk("pf_addr64", 0, PF_ADDR64);
    rc(PFL, 32'h00000200, 0);
    rc(BHI, 32'h0, 0);
    wr(BHI, 32'h5, 4'hF, 0);
    lk(64'h0_01000000, 0, 1);
    wr(PFB, 32'h0101, 4'hF, 0);
    rc(BHI, 32'h1, 0);
    rc(LHI, 32'h1, 0);
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end

  initial begin
    CLK = 0;
    NRST = 0;
    AWVALID = 0;
    WVALID = 0;
    BREADY = 0;
    ARVALID = 0;
    RREADY = 0;
    LOOKUP_VALID = 0;
    AWADDR = 0;
    ARADDR = 0;
    WDATA = 0;
    WSTRB = 0;
    LOOKUP_ADDR = 0;
    fail_count = 0;
    n_compared = 0;
    repeat (2) @(posedge CLK);
    NRST <= 1;
    @(posedge CLK);
    t_reset;
    t_fields;
    t_np;
    t_pf64;
    t_cap;
    end_of_test;
  end
endmodule // bmw_regs_tb

bind bmw_regs bmw_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.CLK(CLK), .NRST(NRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
  .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
  .LOOKUP_ADDR(LOOKUP_ADDR), .LOOKUP_VALID(LOOKUP_VALID), .HIT_VALID(HIT_VALID), .NP_HIT(NP_HIT),
  .PF_ADDR64(PF_ADDR64));
`default_nettype wire
